//--- sfcf_edge.v
// sfcf_edge.v - finds serial clock edges, keeps chip select and data aligned
// assumes: all inputs already synchronised to i_clk, all by the same stages
`timescale 1ns/1ps
`default_nettype none

module sfcf_edge (
	input wire i_clk, // block clock
	input wire i_nrst, // synchronous reset, active low
	input wire i_ce, // clock enable
	input wire i_sck, // synchronised serial clock
	input wire i_cs_n, // synchronised chip select, active low
	input wire [1:0] i_data, // synchronised {shared_out_in, serial in}
	output reg o_sck_rise, // one-cycle pulse on rising serial clock
	output reg o_sck_fall, // one-cycle pulse on falling serial clock
	output reg o_cs_n, // chip select, aligned with the pulses
	output reg [1:0] o_data // data pins, aligned with the pulses
);

	reg sck_r; // last serial clock level

	// data is registered beside the edge so a rising pulse sees the bit
	// that was on the pins when the edge came
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			sck_r <= 1'b0;
			o_sck_rise <= 1'b0;
			o_sck_fall <= 1'b0;
			o_cs_n <= 1'b1;
			o_data <= 2'h0;
		end else if (i_ce) begin
			sck_r <= i_sck;
			o_sck_rise <= i_sck & ~sck_r;
			o_sck_fall <= ~i_sck & sck_r;
			o_cs_n <= i_cs_n;
			o_data <= i_data;
		end
	end

endmodule // sfcf_edge

`default_nettype wire

//--- sfcf_front_end.v
// sfcf_front_end.v - serial command front end of a serial flash device
// assumes: host is an spi master in mode 0 or 3 at no more than i_clk/8;
// array storage and command execution sit behind the user-side ports
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_regs.vh"

module sfcf_front_end (
	input wire i_clk, // block clock, 50 MHz
	input wire i_nrst, // synchronous reset, active low
	input wire i_ce, // clock enable, freezes all state when low
	input wire i_cs_n, // chip select pin, active low
	input wire i_sck, // serial clock pin
	input wire i_sio_in, // serial in / shared_in_out pin level
	input wire i_soi_in, // shared_out_in pin level
	input wire [7:0] i_rd_data, // next read byte, held from o_rd_next
	output reg o_soi_out, // shared_out_in pin drive value
	output reg o_soi_oe, // shared_out_in pin output enable
	output reg o_sio_out, // shared_in_out pin drive value
	output reg o_sio_oe, // shared_in_out pin output enable
	output reg o_cmd_valid, // pulse: opcode and address complete
	output reg [7:0] o_cmd_opcode, // opcode of the current command
	output reg [21:0] o_cmd_addr, // array address of the current command
	output reg o_cmd_end, // pulse: chip select released after o_cmd_valid
	output reg o_wr_valid, // pulse: a write data byte arrived
	output reg [7:0] o_wr_data, // the write data byte
	output reg o_rd_next // pulse: i_rd_data taken, present the next byte
);

	// frame states
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_OPCODE = 3'h1;
	localparam [2:0] ST_ADDR = 3'h2;
	localparam [2:0] ST_DUMMY = 3'h3;
	localparam [2:0] ST_DATA_IN = 3'h4;
	localparam [2:0] ST_DATA_OUT = 3'h5;
	localparam [2:0] ST_HOLD = 3'h6;
	localparam [2:0] ST_IGNORE = 3'h7;

	// decode word: {supported, has address, dummy bytes, direction, dual}
	function [6:0] op_info;
		input [7:0] op;
		begin
			case (op)
				`SFCF_OP_READ_HS: op_info = {2'b11, 2'd2, `SFCF_DIR_OUT, 1'b0};
				`SFCF_OP_READ_FAST: op_info = {2'b11, 2'd1, `SFCF_DIR_OUT, 1'b0};
				`SFCF_OP_READ_SLOW: op_info = {2'b11, 2'd0, `SFCF_DIR_OUT, 1'b0};
				`SFCF_OP_READ_DUAL: op_info = {2'b11, 2'd1, `SFCF_DIR_OUT, 1'b1};
				`SFCF_OP_ERASE_4K,
				`SFCF_OP_ERASE_32K,
				`SFCF_OP_ERASE_64K,
				`SFCF_OP_PROTECT,
				`SFCF_OP_UNPROTECT: op_info = {2'b11, 2'd0, `SFCF_DIR_NONE, 1'b0};
				`SFCF_OP_CHIP_ERASE_A,
				`SFCF_OP_CHIP_ERASE_B,
				`SFCF_OP_SUSPEND,
				`SFCF_OP_RESUME,
				`SFCF_OP_WR_EN,
				`SFCF_OP_WR_DIS,
				`SFCF_OP_POWER_DOWN,
				`SFCF_OP_WAKE: op_info = {2'b10, 2'd0, `SFCF_DIR_NONE, 1'b0};
				`SFCF_OP_PROGRAM,
				`SFCF_OP_LOCKDOWN,
				`SFCF_OP_FREEZE_LOCK,
				`SFCF_OP_OTP_PROG: op_info = {2'b11, 2'd0, `SFCF_DIR_IN, 1'b0};
				`SFCF_OP_PROGRAM_DUAL: op_info = {2'b11, 2'd0, `SFCF_DIR_IN, 1'b1};
				`SFCF_OP_RD_PROT,
				`SFCF_OP_RD_LOCK: op_info = {2'b11, 2'd0, `SFCF_DIR_OUT, 1'b0};
				`SFCF_OP_OTP_READ: op_info = {2'b11, 2'd2, `SFCF_DIR_OUT, 1'b0};
				`SFCF_OP_RD_STATUS,
				`SFCF_OP_READ_ID: op_info = {2'b10, 2'd0, `SFCF_DIR_OUT, 1'b0};
				`SFCF_OP_WR_STATUS1,
				`SFCF_OP_WR_STATUS2,
				`SFCF_OP_RESET: op_info = {2'b10, 2'd0, `SFCF_DIR_IN, 1'b0};
				default: op_info = 7'h00;
			endcase
		end
	endfunction

	// synchronised and edge-aligned pins
	wire [3:0] pins_sync; // {sck, cs_n, soi, si}
	wire sck_rise;
	wire sck_fall;
	wire cs_n;
	wire [1:0] pin_data; // {soi, si}

	// every pin crosses two flip-flops; chip select resets high
	sfcf_sync #(
		.WIDTH(4),
		.RESET_VAL(4'h4)
	) u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_async({i_sck, i_cs_n, i_soi_in, i_sio_in}),
		.o_sync(pins_sync)
	);

	// mode 0 and mode 3 look alike here: only edges count, never the
	// resting level, so a frame may open with the clock high or low
	sfcf_edge u_edge (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_sck(pins_sync[3]),
		.i_cs_n(pins_sync[2]),
		.i_data(pins_sync[1:0]),
		.o_sck_rise(sck_rise),
		.o_sck_fall(sck_fall),
		.o_cs_n(cs_n),
		.o_data(pin_data)
	);

	reg [2:0] state_r;
	reg [2:0] bit_cnt_r; // bits of the current byte taken so far
	reg [1:0] byte_cnt_r; // address or dummy bytes taken so far
	reg [7:0] rx_r; // incoming shift register
	reg [7:0] tx_r; // outgoing shift register
	reg [15:0] addr_r; // first two address bytes; the last comes straight from rx_byte
	reg [1:0] dummy_r; // dummy bytes the command needs
	reg [1:0] dir_r; // data direction of the command
	reg dual_r; // command moves two bits per clock
	reg started_r; // o_cmd_valid was given in this frame

	// two bits per clock only once the data phase is reached
	wire dual_act = dual_r & ((state_r == ST_DATA_IN) | (state_r == ST_DATA_OUT));
	wire [2:0] bit_step = dual_act ? 3'd2 : 3'd1;
	wire last_bit = dual_act ? (bit_cnt_r == 3'd6) : (bit_cnt_r == 3'd7);
	// new bits enter at the bottom so the first bit ends up on top
	wire [7:0] rx_byte = dual_act ? {rx_r[5:0], pin_data} : {rx_r[6:0], pin_data[0]};
	wire [6:0] info = op_info(rx_byte);
	wire [23:0] addr_full = {addr_r[15:0], rx_byte};
	// the read byte to shift out, taken fresh at each byte boundary
	wire [7:0] tx_byte = (bit_cnt_r == 3'd0) ? i_rd_data : tx_r;

	// frame sequencing; chip select high overrides everything
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 3'd0;
			byte_cnt_r <= 2'd0;
			rx_r <= 8'h00;
			tx_r <= 8'h00;
			addr_r <= 16'h0000;
			dummy_r <= 2'd0;
			dir_r <= `SFCF_DIR_NONE;
			dual_r <= 1'b0;
			started_r <= 1'b0;
			o_soi_out <= 1'b0;
			o_soi_oe <= 1'b0;
			o_sio_out <= 1'b0;
			o_sio_oe <= 1'b0;
			o_cmd_valid <= 1'b0;
			o_cmd_opcode <= 8'h00;
			o_cmd_addr <= 22'h00_0000;
			o_cmd_end <= 1'b0;
			o_wr_valid <= 1'b0;
			o_wr_data <= 8'h00;
			o_rd_next <= 1'b0;
		end else if (i_ce) begin
			o_cmd_valid <= 1'b0;
			o_cmd_end <= 1'b0;
			o_wr_valid <= 1'b0;
			o_rd_next <= 1'b0;
			if (cs_n) begin
				// end of frame: drop any partial byte, release the pins
				o_cmd_end <= started_r;
				started_r <= 1'b0;
				state_r <= ST_IDLE;
				bit_cnt_r <= 3'd0;
				byte_cnt_r <= 2'd0;
				o_soi_oe <= 1'b0;
				o_sio_oe <= 1'b0;
			end else begin
				case (state_r)
					ST_IDLE: begin
						// chip select low opens a frame at an opcode boundary
						state_r <= ST_OPCODE;
						bit_cnt_r <= 3'd0;
						byte_cnt_r <= 2'd0;
						dual_r <= 1'b0;
					end
					ST_OPCODE: begin
						if (sck_rise) begin
							rx_r <= rx_byte;
							bit_cnt_r <= bit_cnt_r + bit_step;
							if (last_bit) begin
								if (!info[6]) begin
									// nothing stored: opcode, address and mode keep their values
									state_r <= ST_IGNORE;
								end else begin
									o_cmd_opcode <= rx_byte;
									dummy_r <= info[4:3];
									dir_r <= info[2:1];
									dual_r <= info[0];
									if (info[5]) begin
										state_r <= ST_ADDR;
									end else begin
										// no address: the command is complete now
										o_cmd_valid <= 1'b1;
										started_r <= 1'b1;
										state_r <= (info[2:1] == `SFCF_DIR_IN) ? ST_DATA_IN :
											(info[2:1] == `SFCF_DIR_OUT) ? ST_DATA_OUT : ST_HOLD;
										o_soi_oe <= (info[2:1] == `SFCF_DIR_OUT);
										o_sio_oe <= (info[2:1] == `SFCF_DIR_OUT) & info[0];
									end
								end
							end
						end
					end
					ST_ADDR: begin
						if (sck_rise) begin
							rx_r <= rx_byte;
							bit_cnt_r <= bit_cnt_r + bit_step;
							if (last_bit) begin
								addr_r <= addr_full[15:0];
								byte_cnt_r <= byte_cnt_r + 2'd1;
								if (byte_cnt_r == `SFCF_ADDR_BYTES - 2'd1) begin
									// only the low bits reach the array side
									o_cmd_addr <= addr_full[`SFCF_ARRAY_W-1:0];
									byte_cnt_r <= 2'd0;
									if (dummy_r != 2'd0) begin
										state_r <= ST_DUMMY;
									end else begin
										o_cmd_valid <= 1'b1;
										started_r <= 1'b1;
										state_r <= (dir_r == `SFCF_DIR_IN) ? ST_DATA_IN :
											(dir_r == `SFCF_DIR_OUT) ? ST_DATA_OUT : ST_HOLD;
										o_soi_oe <= (dir_r == `SFCF_DIR_OUT);
										o_sio_oe <= (dir_r == `SFCF_DIR_OUT) & dual_r;
									end
								end
							end
						end
					end
					ST_DUMMY: begin
						// dummy bits are clocked in and thrown away
						if (sck_rise) begin
							bit_cnt_r <= bit_cnt_r + bit_step;
							if (last_bit) begin
								byte_cnt_r <= byte_cnt_r + 2'd1;
								if (byte_cnt_r == dummy_r - 2'd1) begin
									byte_cnt_r <= 2'd0;
									o_cmd_valid <= 1'b1;
									started_r <= 1'b1;
									state_r <= ST_DATA_OUT;
									o_soi_oe <= 1'b1;
									o_sio_oe <= dual_r;
								end
							end
						end
					end
					ST_DATA_IN: begin
						// dual program: shared_out_in stays an input and brings the upper bit
						if (sck_rise) begin
							rx_r <= rx_byte;
							bit_cnt_r <= bit_cnt_r + bit_step;
							if (last_bit) begin
								o_wr_data <= rx_byte;
								o_wr_valid <= 1'b1;
							end
						end
					end
					ST_DATA_OUT: begin
						// the host samples on the rise, so the count moves there
						if (sck_rise) begin
							bit_cnt_r <= bit_cnt_r + bit_step;
						end
						// drive on the fall; a new byte is taken at each boundary
						if (sck_fall) begin
							o_rd_next <= (bit_cnt_r == 3'd0);
							o_soi_out <= tx_byte[7];
							if (dual_r) begin
								// second bit of each pair leaves on shared_in_out
								o_sio_out <= tx_byte[6];
								tx_r <= {tx_byte[5:0], 2'b00};
							end else begin
								tx_r <= {tx_byte[6:0], 1'b0};
							end
						end
					end
					ST_HOLD: begin
						// command complete; extra clocks carry nothing
						state_r <= ST_HOLD;
					end
					ST_IGNORE: begin
						// deaf until chip select goes high and low again
						state_r <= ST_IGNORE;
					end
					default: begin
						state_r <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule // sfcf_front_end

`default_nettype wire

//--- sfcf_front_end_properties.sv
// sfcf_front_end_properties.sv - port timing checks of the command front end
// assumes: bound to sfcf_front_end; i_ce high; pins change on i_clk edges
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_regs.vh"
module sfcf_front_end_chk (
	input wire logic i_clk, // clock
	input wire logic i_nrst, // reset, low
	input wire logic i_ce, // enable
	input wire logic i_cs_n, // pin
	input wire logic i_sck, // pin
	input wire logic i_sio_in, // pin
	input wire logic i_soi_in, // pin
	input wire logic [7:0] i_rd_data, // user
	input wire logic o_soi_out, // pin
	input wire logic o_soi_oe, // pin
	input wire logic o_sio_out, // pin
	input wire logic o_sio_oe, // pin
	input wire logic o_cmd_valid, // user
	input wire logic [7:0] o_cmd_opcode, // user
	input wire logic [21:0] o_cmd_addr, // user
	input wire logic o_cmd_end, // user
	input wire logic o_wr_valid, // user
	input wire logic [7:0] o_wr_data, // user
	input wire logic o_rd_next // user
);
	logic sck_d;
	logic seen_r;
	logic [3:0] rise_age;
	logic [3:0] fall_age;
	// cycles since each pin clock edge; the design lags them by its synchronisers
	always @(posedge i_clk) begin
		sck_d <= i_sck;
		rise_age <= (i_sck && !sck_d) ? 4'h0 : rise_age + {3'h0, rise_age != 4'hf};
		fall_age <= (!i_sck && sck_d) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
		seen_r <= o_cmd_valid | (seen_r & ~o_cmd_end);
		if (!i_nrst) begin
			rise_age <= 4'hf;
			fall_age <= 4'hf;
			seen_r <= 1'b0;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_cs_high;
		i_cs_n [*8];
	endsequence
	sequence s_after_rise;
		rise_age >= 4'h2 && rise_age <= 4'h6;
	endsequence
	sequence s_after_fall;
		fall_age >= 4'h2 && fall_age <= 4'h6;
	endsequence
	chk_oe_idle: assert property (s_cs_high |-> !o_soi_oe && !o_sio_oe)
		else $error("output enable up while chip select high");
	chk_dual_out: assert property (o_sio_oe |-> o_soi_oe && o_cmd_opcode == `SFCF_OP_READ_DUAL)
		else $error("shared_in_out driven outside dual read");
	chk_dual_in: assert property (o_soi_oe |-> o_cmd_opcode != `SFCF_OP_PROGRAM_DUAL)
		else $error("shared_out_in driven during dual program");
	chk_valid_once: assert property (o_cmd_valid |=> !o_cmd_valid)
		else $error("command valid longer than one cycle");
	chk_end_seen: assert property (o_cmd_end |-> seen_r)
		else $error("command end without a command");
	chk_valid_rise: assert property (o_cmd_valid |-> s_after_rise)
		else $error("command valid not after a rising clock");
	chk_wr_rise: assert property (o_wr_valid |-> s_after_rise)
		else $error("write byte not after a rising clock");
	chk_rd_fall: assert property (o_rd_next |-> s_after_fall)
		else $error("read byte not taken at a falling clock");
	chk_out_fall: assert property (o_soi_oe && $past(o_soi_oe) && $changed(o_soi_out)
		|-> s_after_fall)
		else $error("output bit changed away from a falling clock");
endmodule // sfcf_front_end_chk
bind sfcf_front_end sfcf_front_end_chk i_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
	.i_cs_n(i_cs_n), .i_sck(i_sck), .i_sio_in(i_sio_in), .i_soi_in(i_soi_in),
	.i_rd_data(i_rd_data), .o_soi_out(o_soi_out), .o_soi_oe(o_soi_oe), .o_sio_out(o_sio_out),
	.o_sio_oe(o_sio_oe), .o_cmd_valid(o_cmd_valid), .o_cmd_opcode(o_cmd_opcode),
	.o_cmd_addr(o_cmd_addr), .o_cmd_end(o_cmd_end), .o_wr_valid(o_wr_valid),
	.o_wr_data(o_wr_data), .o_rd_next(o_rd_next));
`default_nettype wire

//--- sfcf_host_model.sv
// sfcf_host_model.sv - spi master model for the command front end
// assumes: driven from the bench clock; serial clock half period is four cycles
`timescale 1ns/1ps
`default_nettype none
module sfcf_host_model (
	input wire logic i_clk, // bench clock
	input wire logic i_soi, // shared_out_in wire level
	input wire logic i_sio, // shared_in_out wire level
	output logic o_cs_n = 1'b1, // chip select, low active
	output logic o_sck = 1'b0, // serial clock
	output logic o_sio = 1'b0, // serial in drive
	output logic o_soi = 1'b0, // shared_out_in drive
	output logic o_soi_oe = 1'b0 // host drives shared_out_in
);
	// one clock: set data while low, device takes it at the rise
	// read late in the high phase, as the device answer lags the fall
	task automatic clk_bit(input logic [1:0] d, input logic drv, output logic [1:0] q);
		@(posedge i_clk);
		o_sck <= 1'b0;
		o_soi_oe <= drv;
		{o_soi, o_sio} <= d;
		repeat (4) @(posedge i_clk);
		o_sck <= 1'b1;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		q = {i_soi, i_sio};
	endtask
	// one byte, msb first, two bits a clock when dual
	task automatic xfer(input logic [7:0] b, input logic dual, input logic drv,
		output logic [7:0] r);
		logic [1:0] q;
		for (int i = 7; i >= 0; i = i - (dual ? 2 : 1)) begin
			clk_bit(dual ? b[i -: 2] : {1'b0, b[i]}, drv, q);
			r = dual ? {r[5:0], q} : {r[6:0], q[1]};
		end
	endtask
	// clock rests low in mode 0, high in mode 3
	task automatic start(input logic mode3);
		@(posedge i_clk);
		o_sck <= mode3;
		repeat (6) @(posedge i_clk);
		o_cs_n <= 1'b0;
		repeat (6) @(posedge i_clk);
	endtask
	task automatic stop(input logic mode3);
		@(posedge i_clk);
		o_sck <= mode3;
		o_soi_oe <= 1'b0;
		repeat (4) @(posedge i_clk);
		o_cs_n <= 1'b1;
		repeat (8) @(posedge i_clk);
	endtask
endmodule // sfcf_host_model
`default_nettype wire

//--- sfcf_regs.vh
// sfcf_regs.vh - constants of the serial flash command front end
// assumes: included by bare name from the front end, its checks and the bench
`ifndef SFCF_REGS_VH
`define SFCF_REGS_VH

// link framing
`define SFCF_BYTE_W 8
`define SFCF_ADDR_W 24
`define SFCF_ARRAY_W 22
`define SFCF_ADDR_BYTES 2'd3
`define SFCF_SYNC_STAGES 2

// data direction codes carried in the decode word
`define SFCF_DIR_NONE 2'h0
`define SFCF_DIR_IN 2'h1
`define SFCF_DIR_OUT 2'h2

// recognised opcodes
`define SFCF_OP_READ_HS 8'h1b
`define SFCF_OP_READ_FAST 8'h0b
`define SFCF_OP_READ_SLOW 8'h03
`define SFCF_OP_READ_DUAL 8'h3b
`define SFCF_OP_ERASE_4K 8'h20
`define SFCF_OP_ERASE_32K 8'h52
`define SFCF_OP_ERASE_64K 8'hd8
`define SFCF_OP_CHIP_ERASE_A 8'h60
`define SFCF_OP_CHIP_ERASE_B 8'hc7
`define SFCF_OP_PROGRAM 8'h02
`define SFCF_OP_PROGRAM_DUAL 8'ha2
`define SFCF_OP_SUSPEND 8'hb0
`define SFCF_OP_RESUME 8'hd0
`define SFCF_OP_WR_EN 8'h06
`define SFCF_OP_WR_DIS 8'h04
`define SFCF_OP_PROTECT 8'h36
`define SFCF_OP_UNPROTECT 8'h39
`define SFCF_OP_RD_PROT 8'h3c
`define SFCF_OP_LOCKDOWN 8'h33
`define SFCF_OP_FREEZE_LOCK 8'h34
`define SFCF_OP_RD_LOCK 8'h35
`define SFCF_OP_OTP_PROG 8'h9b
`define SFCF_OP_OTP_READ 8'h77
`define SFCF_OP_RD_STATUS 8'h05
`define SFCF_OP_WR_STATUS1 8'h01
`define SFCF_OP_WR_STATUS2 8'h31
`define SFCF_OP_RESET 8'hf0
`define SFCF_OP_READ_ID 8'h9f
`define SFCF_OP_POWER_DOWN 8'hb9
`define SFCF_OP_WAKE 8'hab

`endif

//--- sfcf_sync.v
// sfcf_sync.v - two flip-flop synchroniser for a group of pin levels
// assumes: inputs are asynchronous levels; outputs are in the i_clk domain
`timescale 1ns/1ps
`default_nettype none

module sfcf_sync #(
	parameter WIDTH = 4,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire i_clk, // block clock
	input wire i_nrst, // synchronous reset, active low
	input wire i_ce, // clock enable, freezes state when low
	input wire [WIDTH-1:0] i_async, // raw pin levels
	output reg [WIDTH-1:0] o_sync // levels safe to use in i_clk domain
);

	reg [WIDTH-1:0] meta_r; // first stage: only o_sync reads it

	// plain two-stage chain; no logic between the stages
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			meta_r <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else if (i_ce) begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule // sfcf_sync

`default_nettype wire

//--- testbench.sv
// testbench.sv - self-checking bench of the command front end
// assumes: host model drives the pins; the bench plays the user side
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_regs.vh"
module testbench;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic junk = 1'b0;
	logic [7:0] i_rd_data = 8'h00;
	logic [7:0] rd_b[8];
	logic [7:0] wr_q[$];
	int bad_count = 0;
	int samples_checked = 0;
	int n_valid = 0;
	int n_end = 0;
	int rd_i = 0;
	wire cs_n, sck, h_sio, h_soi, h_oe, soi_w, sio_w, soi_out, soi_oe, sio_out, sio_oe;
	wire cmd_valid, cmd_end, wr_valid, rd_next;
	wire [7:0] cmd_opcode, wr_data;
	wire [21:0] cmd_addr;
	always #10 i_clk = ~i_clk;
	// a released shared_out_in wire shows a changing pattern; shared_in_out falls back to the host drive
	always @(posedge i_clk) junk <= ~junk;
	assign soi_w = soi_oe ? soi_out : (h_oe ? h_soi : junk);
	assign sio_w = sio_oe ? sio_out : h_sio;
	sfcf_host_model i_host (.i_clk(i_clk), .i_soi(soi_w), .i_sio(sio_w), .o_cs_n(cs_n),
		.o_sck(sck), .o_sio(h_sio), .o_soi(h_soi), .o_soi_oe(h_oe));
	sfcf_front_end i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_cs_n(cs_n),
		.i_sck(sck), .i_sio_in(sio_w), .i_soi_in(soi_w), .i_rd_data(i_rd_data),
		.o_soi_out(soi_out), .o_soi_oe(soi_oe), .o_sio_out(sio_out), .o_sio_oe(sio_oe),
		.o_cmd_valid(cmd_valid), .o_cmd_opcode(cmd_opcode), .o_cmd_addr(cmd_addr),
		.o_cmd_end(cmd_end), .o_wr_valid(wr_valid), .o_wr_data(wr_data), .o_rd_next(rd_next));
	// user side model: counts pulses, keeps write bytes, serves read bytes
	always @(posedge i_clk) begin
		if (cmd_valid === 1'b1) n_valid <= n_valid + 1;
		if (cmd_end === 1'b1) n_end <= n_end + 1;
		if (wr_valid === 1'b1) wr_q.push_back(wr_data);
		if (rd_next === 1'b1) begin
			rd_i <= rd_i + 1;
			i_rd_data <= rd_b[(rd_i + 1) % 8];
		end
	end
	task automatic conclude();
		$display("checked %0d, mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: value %h, want %h", $time, g, e);
		end
	endtask
	task automatic cmp_cnt(input int g, input int e);
		samples_checked++;
		if (g != e) begin
			bad_count++;
			$display("unexpected at %0t: count %0d, want %0d", $time, g, e);
		end
	endtask
	// preamble of one command, then the command word on the user side
	task automatic cmd(input logic [7:0] op, input logic m3, input int nab, input int ndum,
		input logic [23:0] a);
		int v;
		logic [7:0] r;
		v = n_valid;
		rd_i = 0;
		i_rd_data <= rd_b[0];
		i_host.start(m3);
		i_host.xfer(op, 1'b0, 1'b0, r);
		for (int k = 0; k < nab; k++) i_host.xfer(a[23 - 8 * k -: 8], 1'b0, 1'b0, r);
		repeat (ndum) i_host.xfer(8'($urandom), 1'b0, 1'b0, r);
		repeat (3) @(posedge i_clk);
		cmp_cnt(n_valid, v + 1);
		cmp_val(cmd_opcode, op);
		if (nab > 0) cmp_val(cmd_addr, a[21:0]);
	endtask
	task automatic fin(input logic m3, input int want);
		int e;
		e = n_end;
		i_host.stop(m3);
		cmp_cnt(n_end, e + want);
	endtask
	initial begin
		repeat (60000) @(posedge i_clk);
		bad_count++;
		$display("unexpected at %0t: run did not finish", $time);
		conclude();
	end
	initial begin
		logic [7:0] r;
		logic [1:0] q;
		logic [23:0] a;
		logic [7:0] op;
		int n;
		void'($urandom(32'hbf1e_3547));
		foreach (rd_b[k]) rd_b[k] = 8'($urandom);
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		// slow read in mode 0, fast read in mode 3, two dummy bytes in mode 0;
		// top address bits set
		for (int m = 0; m < 3; m++) begin
			a = 24'($urandom) | 24'hc0_0000;
			op = (m == 2) ? `SFCF_OP_READ_HS : (m ? `SFCF_OP_READ_FAST : `SFCF_OP_READ_SLOW);
			cmd(op, m[0], 3, m, a);
			for (int k = 0; k < 3; k++) begin
				i_host.xfer(8'h00, 1'b0, 1'b0, r);
				cmp_val(r, rd_b[k]);
			end
			fin(m[0], 1);
		end
		// dual read at the top of the array
		cmd(`SFCF_OP_READ_DUAL, 1'b0, 3, 1, 24'h3f_ffff);
		for (int k = 0; k < 2; k++) begin
			i_host.xfer(8'h00, 1'b1, 1'b0, r);
			cmp_val(r, rd_b[k]);
		end
		fin(1'b0, 1);
		// single then dual program of two random bytes
		for (int m = 0; m < 2; m++) begin
			a = 24'($urandom);
			cmd(m ? `SFCF_OP_PROGRAM_DUAL : `SFCF_OP_PROGRAM, 1'b1, 3, 0, a);
			wr_q.delete();
			for (int k = 0; k < 2; k++) i_host.xfer(rd_b[k + 4], m[0], m[0], r);
			repeat (6) @(posedge i_clk);
			cmp_cnt(wr_q.size(), 2);
			for (int k = 0; k < 2; k++) cmp_val(wr_q[k], rd_b[k + 4]);
			fin(1'b1, 1);
		end
		// unsupported opcode, then bytes that would be a valid command
		n = n_valid;
		i_host.start(1'b0);
		i_host.xfer(8'h00, 1'b0, 1'b0, r);
		for (int k = 0; k < 4; k++) i_host.xfer(`SFCF_OP_WR_EN, 1'b0, 1'b0, r);
		fin(1'b0, 0);
		cmp_cnt(n_valid, n);
		cmp_val(cmd_opcode, `SFCF_OP_PROGRAM_DUAL);
		cmp_val(cmd_addr, a[21:0]);
		// chip select released in the third address byte, after its third bit
		i_host.start(1'b1);
		i_host.xfer(`SFCF_OP_ERASE_4K, 1'b0, 1'b0, r);
		for (int k = 0; k < 2; k++) i_host.xfer(8'($urandom), 1'b0, 1'b0, r);
		for (int k = 0; k < 3; k++) i_host.clk_bit(2'b01, 1'b0, q);
		fin(1'b1, 0);
		cmp_cnt(n_valid, n);
		// the next frames start at a fresh opcode boundary
		cmd(`SFCF_OP_PROTECT, 1'b1, 3, 0, 24'h12_3456);
		fin(1'b1, 1);
		cmd(`SFCF_OP_WR_EN, 1'b0, 0, 0, 24'h00_0000);
		fin(1'b0, 1);
		// status read: no address, data follows the opcode at once
		cmd(`SFCF_OP_RD_STATUS, 1'b1, 0, 0, 24'h00_0000);
		i_host.xfer(8'h00, 1'b0, 1'b0, r);
		cmp_val(r, rd_b[0]);
		fin(1'b1, 1);
		conclude();
	end
endmodule // testbench
`default_nettype wire
